// ### dv/bhr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module bhr_ctrl_model (
    // Clock and reset
    input wire logic  clk_sys_in,
    input wire logic  rst_n_in,
    // Byte link
    input wire logic  rx_ready_in,
    output logic      rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic      rx_error_out
);
    logic [8:0] q [$];
    logic       taken;
    // Bit 8 marks a byte sent with a serial error
    task automatic push(input logic [8:0] b);
        q.push_back(b);
    endtask
    initial
    begin
        rx_valid_out = 1'b0;
        rx_data_out  = 8'h00;
        rx_error_out = 1'b0;
    end
    always @(posedge clk_sys_in)
    begin
        taken = rx_valid_out && rx_ready_in;
        if (!rst_n_in)
            q.delete();
        else if (taken)
            void'(q.pop_front());
        #1;
        if (!rst_n_in || taken || !rx_valid_out)
        begin
            if (rst_n_in && q.size() > 0 && $urandom_range(3) != 0)
            begin
                rx_valid_out = 1'b1;
                rx_data_out  = q[0][7:0];
                rx_error_out = q[0][8];
            end
            else
            begin
                // Released line must not look like the last byte
                rx_valid_out = 1'b0;
                rx_data_out  = ~rx_data_out;
                rx_error_out = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/bhr_framer_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "bhr_defs.svh"
module bhr_framer_sva (
    // Clock and reset
    input wire logic              clk_sys_in,
    input wire logic              rst_n_in,
    // Framer inputs
    input wire logic              cmd_start_in,
    input wire logic [7:0]        cmd_code_in,
    input wire logic              rx_valid_in,
    input wire logic              rx_error_in,
    input wire logic              mem_valid_in,
    input wire logic [7:0]        mem_data_in,
    input wire logic              mem_in_range_in,
    input wire logic              pay_ready_in,
    input wire logic              sum_send_in,
    input wire logic              tx_ready_in,
    // Framer outputs
    input wire logic              rx_ready_out,
    input wire logic              pay_valid_out,
    input wire bhr_pkg::bhr_rec_s pay_out,
    input wire logic              tx_valid_out,
    input wire bhr_pkg::bhr_tx_s  tx_out,
    input wire logic              idle_out,
    input wire logic [15:0]       sum_out
);
    logic       mem_mode_q;
    // Commands whose sum comes from the memory bus
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
            mem_mode_q <= 1'b0;
        else if (cmd_start_in && !idle_out)
            mem_mode_q <= cmd_code_in inside {`BHR_CMD_ERASE,
                `BHR_CMD_WRITE, `BHR_CMD_READ};
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_idle_hold;
        idle_out |=> idle_out && !rx_ready_out && !tx_valid_out;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle state left");
    property p_rx_err;
        rx_valid_in && rx_error_in && rx_ready_out |=> idle_out;
    endproperty
    a_rx_err: assert property (p_rx_err)
        else $error("serial error not idled");
    property p_sum_clr;
        cmd_start_in && !idle_out |=> sum_out == 16'h0000;
    endproperty
    a_sum_clr: assert property (p_sum_clr)
        else $error("sum not cleared");
    property p_sum_add;
        mem_mode_q && mem_valid_in && mem_in_range_in && !cmd_start_in
        && !idle_out |=> sum_out == 16'($past(sum_out)
        + 16'($past(mem_data_in)));
    endproperty
    a_sum_add: assert property (p_sum_add)
        else $error("sum add wrong");
    property p_sum_keep;
        mem_mode_q && mem_valid_in && !mem_in_range_in && !cmd_start_in
        && !idle_out |=> $stable(sum_out);
    endproperty
    a_sum_keep: assert property (p_sum_keep)
        else $error("out of range byte summed");
    property p_tx_go;
        sum_send_in && !idle_out |=> tx_valid_out && !tx_out.last
        && tx_out.data == sum_out[15:8];
    endproperty
    a_tx_go: assert property (p_tx_go)
        else $error("upper sum byte not sent");
    property p_tx_lo;
        tx_valid_out && tx_ready_in && !tx_out.last |-> ##[1:2]
        (tx_valid_out && tx_out.last && tx_out.data == sum_out[7:0]);
    endproperty
    a_tx_lo: assert property (p_tx_lo)
        else $error("lower sum byte not sent");
    property p_pay_hold;
        pay_valid_out && !pay_ready_in |=> pay_valid_out
        && $stable(pay_out);
    endproperty
    a_pay_hold: assert property (p_pay_hold)
        else $error("payload dropped");
endmodule
`default_nettype wire

// ### dv/bhr_framer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bhr_defs.svh"
module bhr_framer_test;
    logic              clk_sys_in, rst_n_in, cmd_start_in;
    logic              rx_valid_in, rx_error_in, rx_ready_out;
    logic              mem_valid_in, mem_in_range_in, resp_valid_in;
    logic              pay_valid_out, pay_ready_in, end_rec_out;
    logic              sum_send_in, tx_valid_out, tx_ready_in, idle_out;
    logic [7:0]        cmd_code_in, rx_data_in, mem_data_in, resp_data_in;
    logic [15:0]       sum_out, esum;
    bhr_pkg::bhr_rec_s pay_out;
    bhr_pkg::bhr_tx_s  tx_out;
    logic [7:0]        pl [256];
    int                err_total, tests_run;
    bhr_framer i_dut (
        .clk_sys_in, .rst_n_in, .cmd_start_in, .cmd_code_in,
        .rx_valid_in, .rx_data_in, .rx_error_in, .rx_ready_out,
        .mem_valid_in, .mem_data_in, .mem_in_range_in, .resp_valid_in,
        .resp_data_in, .pay_valid_out, .pay_ready_in, .pay_out,
        .end_rec_out, .sum_send_in, .tx_valid_out, .tx_ready_in,
        .tx_out, .idle_out, .sum_out
    );
    bhr_ctrl_model i_ctrl (
        .clk_sys_in, .rst_n_in, .rx_ready_in(rx_ready_out),
        .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
        .rx_error_out(rx_error_in)
    );
    initial
    begin
        clk_sys_in = 1'b0;
        forever
            #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic check(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        cmd_code_in  = c;
        cmd_start_in = 1'b1;
        tick();
        cmd_start_in = 1'b0;
        esum = 16'h0000;
    endtask
    task automatic send_rec(input logic [7:0] typ, len, input logic [15:0]
                            ofs, input logic [7:0] bad = 0, int ea = -1);
        logic [7:0] b [$];
        logic [7:0] s;
        b = '{8'h3A, len, ofs[15:8], ofs[7:0], typ};
        for (int i = 0; i < len; i++)
            b.push_back(pl[i]);
        s = 8'h00;
        foreach (b[i])
            s += (i > 0) ? b[i] : 8'h00;
        b.push_back((8'h00 - s) ^ bad);
        foreach (b[i])
            i_ctrl.push({1'(i == ea), b[i]});
    endtask
    // Random ready until the transfer is seen
    task automatic hs(ref logic rdy, ref logic vld);
        int n;
        n = 0;
        rdy = 1'b0;
        while (!(vld === 1'b1 && rdy === 1'b1) && n < 400)
        begin
            tick();
            rdy = 1'($urandom_range(1));
            n++;
        end
    endtask
    task automatic tx_check(input logic [15:0] e);
        check("sum", e, sum_out);
        sum_send_in = 1'b1;
        tick();
        sum_send_in = 1'b0;
        for (int i = 1; i >= 0; i--)
        begin
            hs(tx_ready_in, tx_valid_out);
            check("tx byte", 16'(e[i*8 +: 8]), {8'h00, tx_out.data});
            check("tx last", 16'(i == 0), {15'h0, tx_out.last});
            tick();
        end
        tx_ready_in = 1'b0;
    endtask
    initial
    begin
        #500_000;
        err_total++;
        results();
    end
    initial
    begin
        logic [7:0]  mc [3];
        logic [15:0] a;
        int          n;
        {cmd_start_in, cmd_code_in, mem_valid_in, mem_data_in} = '0;
        {mem_in_range_in, resp_valid_in, resp_data_in} = '0;
        {pay_ready_in, sum_send_in, tx_ready_in, rst_n_in} = '0;
        err_total = 0;
        tests_run = 0;
        mc = '{`BHR_CMD_ERASE, `BHR_CMD_WRITE, `BHR_CMD_READ};
        void'($urandom(83008));
        repeat (4) tick();
        rst_n_in = 1'b1;
        cmd(`BHR_CMD_RAM);
        {pl[0], pl[1]} = `BHR_SEG_LIMIT;
        send_rec(`BHR_TYPE_EXT, `BHR_EXT_LEN, 16'h0000);
        for (int r = 0; r < 2; r++)
        begin
            i_ctrl.push({1'b0, 8'($urandom_range(8'h39))});
            n = (r == 0) ? 8 : $urandom_range(1, 3);
            a = 16'($urandom);
            for (int i = 0; i < n; i++)
                pl[i] = 8'($urandom);
            send_rec(`BHR_TYPE_DATA, 8'(n), a);
            repeat (12) tick();
            for (int i = 0; i < n; i++)
            begin
                hs(pay_ready_in, pay_valid_out);
                check("pay data", {8'h00, pl[i]}, {8'h00, pay_out.data});
                check("pay addr", 16'(a + i), pay_out.addr);
                check("pay seg", `BHR_SEG_LIMIT, pay_out.seg);
                esum += 16'(pl[i]);
                tick();
            end
            pay_ready_in = 1'b0;
            check("pay empty", 16'h0000, {15'h0, pay_valid_out});
        end
        send_rec(`BHR_TYPE_END, `BHR_END_LEN, 16'h0000);
        for (n = 0; end_rec_out !== 1'b1 && n < 100; n++)
            tick();
        check("end pulse", 16'h0001, {15'h0, end_rec_out});
        check("idle", 16'h0000, {15'h0, idle_out});
        tx_check(esum);
        $display("Record load test done");
        foreach (mc[k])
        begin
            cmd(mc[k]);
            // First 300 cycles sum to 16'hFFFF, so the rest must wrap
            for (int i = 0; i < 400; i++)
            begin
                mem_valid_in    = (i < 300) || 1'($urandom_range(1));
                mem_in_range_in = (i % 7) != 3;
                mem_data_in     = (i < 300) ? 8'hFF : 8'($urandom);
                if (mem_valid_in && mem_in_range_in)
                    esum += 16'(mem_data_in);
                tick();
            end
            mem_valid_in = 1'b0;
            tx_check(esum);
        end
        $display("Memory sum test done");
        for (int k = 0; k < 2; k++)
        begin
            cmd(k ? `BHR_CMD_STATUS : `BHR_CMD_ID);
            for (int i = 1; i <= 20; i++)
            begin
                resp_valid_in = 1'b1;
                resp_data_in  = 8'($urandom);
                if (i >= 9 && i <= (k ? 12 : 18))
                    esum += 16'(resp_data_in);
                tick();
            end
            resp_valid_in = 1'b0;
            tx_check(esum);
        end
        $display("Response sum test done");
        for (int k = 0; k < 7; k++)
        begin
            rst_n_in = 1'b0;
            repeat (4) tick();
            rst_n_in = 1'b1;
            cmd(`BHR_CMD_WRITE);
            pay_ready_in = 1'b1;
            pl[0] = (k == 4) ? 8'h20 : 8'h00;
            pl[1] = (k == 4) ? 8'h01 : 8'h00;
            pl[2] = 8'h00;
            case (k)
            0: send_rec(8'h03, 8'h01, 16'h0000);
            1: send_rec(`BHR_TYPE_DATA, 8'h01, 16'h0100, 8'h01);
            2: send_rec(`BHR_TYPE_EXT, 8'h03, 16'h0000);
            3: send_rec(`BHR_TYPE_EXT, `BHR_EXT_LEN, 16'h0001);
            4:
            begin
                send_rec(`BHR_TYPE_EXT, `BHR_EXT_LEN, 16'h0000);
                repeat (30) tick();
                check("idle early", 16'h0000, {15'h0, idle_out});
                send_rec(`BHR_TYPE_DATA, 8'h01, 16'h0000);
            end
            5: send_rec(`BHR_TYPE_END, 8'h01, 16'h0000);
            default: send_rec(`BHR_TYPE_DATA, 8'h01, 16'h0000, 8'h00, 3);
            endcase
            for (n = 0; idle_out !== 1'b1 && n < 200; n++)
                tick();
            check("idle", 16'h0001, {15'h0, idle_out});
            check("rx ready", 16'h0000, {15'h0, rx_ready_out});
            cmd(`BHR_CMD_ERASE);
            sum_send_in = 1'b1;
            tick();
            sum_send_in = 1'b0;
            tick();
            check("tx valid", 16'h0000, {15'h0, tx_valid_out});
        end
        pay_ready_in = 1'b0;
        $display("Format error test done");
        results();
    end
endmodule
bind bhr_framer bhr_framer_sva i_sva (
    .clk_sys_in, .rst_n_in, .cmd_start_in, .cmd_code_in, .rx_valid_in,
    .rx_error_in, .mem_valid_in, .mem_data_in, .mem_in_range_in,
    .pay_ready_in, .sum_send_in, .tx_ready_in, .rx_ready_out,
    .pay_valid_out, .pay_out, .tx_valid_out, .tx_out, .idle_out, .sum_out
);
`default_nettype wire

// ### rtl/bhr_defs.svh
`ifndef BHR_DEFS_SVH
`define BHR_DEFS_SVH
`define BHR_START_MARK   8'h3A
`define BHR_TYPE_DATA    8'h00
`define BHR_TYPE_END     8'h01
`define BHR_TYPE_EXT     8'h02
`define BHR_EXT_LEN      8'h02
`define BHR_END_LEN      8'h00
`define BHR_SEG_LIMIT    16'h2000
`define BHR_CMD_ERASE    8'hF0
`define BHR_CMD_WRITE    8'h30
`define BHR_CMD_READ     8'h40
`define BHR_CMD_RAM      8'h60
`define BHR_CMD_ID       8'hC0
`define BHR_CMD_STATUS   8'hC3
`define BHR_ID_FIRST     8'h09
`define BHR_ID_LAST      8'h12
`define BHR_ST_FIRST     8'h09
`define BHR_ST_LAST      8'h0C
`define BHR_FIFO_DEPTH   4
`endif

// ### rtl/bhr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module bhr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Drain side
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_q != '0);
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem_q[rp_q];

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// ### rtl/bhr_framer.sv
`timescale 1ns/100ps
`default_nettype none
`include "bhr_defs.svh"
module bhr_framer (
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_n_in,
    // Command start from the loader sequencer
    input  wire logic                  cmd_start_in,
    input  wire logic [7:0]            cmd_code_in,
    // Received serial bytes
    input  wire logic                  rx_valid_in,
    input  wire logic [7:0]            rx_data_in,
    input  wire logic                  rx_error_in,
    output logic                       rx_ready_out,
    // Memory or response bytes to sum (erase, write, read, ID, status)
    input  wire logic                  mem_valid_in,
    input  wire logic [7:0]            mem_data_in,
    input  wire logic                  mem_in_range_in,
    input  wire logic                  resp_valid_in,
    input  wire logic [7:0]            resp_data_in,
    // Parsed payload bytes toward memory
    output logic                       pay_valid_out,
    input  wire logic                  pay_ready_in,
    output bhr_pkg::bhr_rec_s          pay_out,
    // End of a record stream
    output logic                       end_rec_out,
    // Checksum send request and bytes
    input  wire logic                  sum_send_in,
    output logic                       tx_valid_out,
    input  wire logic                  tx_ready_in,
    output bhr_pkg::bhr_tx_s           tx_out,
    // Status
    output logic                       idle_out,
    output logic [15:0]                sum_out
);
    bhr_pkg::bhr_state_e state_q;
    logic [7:0]          cmd_q;
    logic                parse_q;
    logic [7:0]          len_q;
    logic [7:0]          cnt_q;
    logic [7:0]          type_q;
    logic [15:0]         addr_q;
    logic [15:0]         seg_q;
    logic [15:0]         ext_q;
    logic                seg_bad_q;
    logic [7:0]          rsum_q;
    logic [15:0]         acc_q;
    logic [7:0]          resp_idx_q;
    logic [1:0]          tx_cnt_q;
    logic                end_q;
    logic                take;
    logic                fmt_err;
    logic                fifo_ready;
    logic [7:0]          rsum_next;
    bhr_pkg::bhr_rec_s   push_rec;
    logic                push_v;

    function automatic logic is_record_cmd(input logic [7:0] c);
        // Records carry data only for flash write and RAM loader
        return (c == `BHR_CMD_WRITE) || (c == `BHR_CMD_RAM);
    endfunction

    // Header checks made as the type byte arrives
    function automatic logic hdr_bad(input logic [7:0] t, l,
                                     input logic [15:0] a, input logic sb);
        return !(t inside {`BHR_TYPE_DATA, `BHR_TYPE_END, `BHR_TYPE_EXT}) ||
               (t == `BHR_TYPE_EXT && (l != `BHR_EXT_LEN || a != 16'h0000)) ||
               (t == `BHR_TYPE_END && l != `BHR_END_LEN) ||
               (t == `BHR_TYPE_DATA && (sb || l == 8'h00));
    endfunction

    // Stall the receiver while the payload FIFO is full
    assign rx_ready_out = fifo_ready && (state_q != bhr_pkg::BHR_IDLE);
    assign take         = rx_valid_in && rx_ready_out && parse_q;
    assign rsum_next    = rsum_q + rx_data_in;
    assign idle_out     = (state_q == bhr_pkg::BHR_IDLE);
    assign sum_out      = acc_q;
    assign end_rec_out  = end_q;

    assign fmt_err = take &&
                     ((state_q == bhr_pkg::BHR_TYPE &&
                       hdr_bad(rx_data_in, len_q, addr_q, seg_bad_q)) ||
                      (state_q == bhr_pkg::BHR_CSUM && rsum_next != 8'h00));

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            cmd_q   <= 8'h00;
            parse_q <= 1'b0;
        end
        else if (cmd_start_in && state_q != bhr_pkg::BHR_IDLE)
        begin
            cmd_q   <= cmd_code_in;
            parse_q <= is_record_cmd(cmd_code_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= bhr_pkg::BHR_WAIT_MARK;
        end
        else if (state_q == bhr_pkg::BHR_IDLE)
        begin
            state_q <= bhr_pkg::BHR_IDLE;
        end
        else if ((rx_error_in && rx_valid_in) || fmt_err)
        begin
            state_q <= bhr_pkg::BHR_IDLE;
        end
        else if (cmd_start_in)
        begin
            state_q <= bhr_pkg::BHR_WAIT_MARK;
        end
        else if (take)
        begin
            case (state_q)
                bhr_pkg::BHR_WAIT_MARK:
                begin
                    if (rx_data_in == `BHR_START_MARK)
                    begin
                        state_q <= bhr_pkg::BHR_LEN;
                    end
                end
                bhr_pkg::BHR_LEN:     state_q <= bhr_pkg::BHR_ADDR_HI;
                bhr_pkg::BHR_ADDR_HI: state_q <= bhr_pkg::BHR_ADDR_LO;
                bhr_pkg::BHR_ADDR_LO: state_q <= bhr_pkg::BHR_TYPE;
                bhr_pkg::BHR_TYPE:
                begin
                    state_q <= (len_q == 8'h00) ? bhr_pkg::BHR_CSUM
                                                : bhr_pkg::BHR_PAYLOAD;
                end
                bhr_pkg::BHR_PAYLOAD:
                begin
                    if (cnt_q == len_q - 8'h01)
                    begin
                        state_q <= bhr_pkg::BHR_CSUM;
                    end
                end
                bhr_pkg::BHR_CSUM:    state_q <= bhr_pkg::BHR_WAIT_MARK;
                default:              state_q <= bhr_pkg::BHR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            len_q  <= 8'h00;
            addr_q <= 16'h0000;
            type_q <= 8'h00;
            cnt_q  <= 8'h00;
            rsum_q <= 8'h00;
        end
        else if (take)
        begin
            rsum_q <= (state_q == bhr_pkg::BHR_WAIT_MARK) ? 8'h00 : rsum_next;
            case (state_q)
                bhr_pkg::BHR_LEN:     len_q <= rx_data_in;
                bhr_pkg::BHR_ADDR_HI: addr_q[15:8] <= rx_data_in;
                bhr_pkg::BHR_ADDR_LO: addr_q[7:0] <= rx_data_in;
                bhr_pkg::BHR_TYPE:
                begin
                    type_q <= rx_data_in;
                    cnt_q  <= 8'h00;
                end
                bhr_pkg::BHR_PAYLOAD: cnt_q <= cnt_q + 8'h01;
                default:              cnt_q <= cnt_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            ext_q     <= 16'h0000;
            seg_q     <= 16'h0000;
            seg_bad_q <= 1'b0;
        end
        else if (take && state_q == bhr_pkg::BHR_PAYLOAD &&
                 type_q == `BHR_TYPE_EXT)
        begin
            ext_q <= {ext_q[7:0], rx_data_in};
        end
        // Segment takes effect only once its record checksum is good
        else if (take && state_q == bhr_pkg::BHR_CSUM &&
                 type_q == `BHR_TYPE_EXT && !fmt_err)
        begin
            seg_q     <= ext_q;
            seg_bad_q <= (ext_q > `BHR_SEG_LIMIT);
        end
        else if (cmd_start_in)
        begin
            seg_q     <= 16'h0000;
            seg_bad_q <= 1'b0;
        end
    end

    // Payload goes out before its checksum is seen; idle blocks the rest
    assign push_v = take && state_q == bhr_pkg::BHR_PAYLOAD &&
                    type_q == `BHR_TYPE_DATA;
    assign push_rec = '{data: rx_data_in,
                        addr: addr_q + {8'h00, cnt_q},
                        seg:  seg_q};

    bhr_fifo #(
        .WIDTH ($bits(bhr_pkg::bhr_rec_s)),
        .DEPTH (`BHR_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .wr_valid_in  (push_v),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (push_rec),
        .rd_valid_out (pay_valid_out),
        .rd_ready_in  (pay_ready_in),
        .rd_data_out  (pay_out)
    );

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            end_q <= 1'b0;
        end
        else
        begin
            end_q <= take && state_q == bhr_pkg::BHR_CSUM &&
                     type_q == `BHR_TYPE_END && !fmt_err;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            resp_idx_q <= 8'h00;
        end
        else if (cmd_start_in)
        begin
            resp_idx_q <= 8'h00;
        end
        else if (resp_valid_in && resp_idx_q != 8'hFF)
        begin
            resp_idx_q <= resp_idx_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            acc_q <= 16'h0000;
        end
        else if (cmd_start_in)
        begin
            acc_q <= 16'h0000;
        end
        else
        begin
            case (cmd_q)
                `BHR_CMD_ID:
                begin
                    if (resp_valid_in && resp_idx_q + 8'h01 >= `BHR_ID_FIRST &&
                        resp_idx_q + 8'h01 <= `BHR_ID_LAST)
                    begin
                        acc_q <= acc_q + {8'h00, resp_data_in};
                    end
                end
                `BHR_CMD_STATUS:
                begin
                    if (resp_valid_in && resp_idx_q + 8'h01 >= `BHR_ST_FIRST &&
                        resp_idx_q + 8'h01 <= `BHR_ST_LAST)
                    begin
                        acc_q <= acc_q + {8'h00, resp_data_in};
                    end
                end
                `BHR_CMD_RAM:
                begin
                    if (push_v)
                    begin
                        acc_q <= acc_q + {8'h00, rx_data_in};
                    end
                end
                default:
                begin
                    if (mem_valid_in && mem_in_range_in)
                    begin
                        acc_q <= acc_q + {8'h00, mem_data_in};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            tx_cnt_q <= 2'd0;
        end
        else if (state_q == bhr_pkg::BHR_IDLE)
        begin
            tx_cnt_q <= 2'd0;
        end
        else if (sum_send_in && tx_cnt_q == 2'd0)
        begin
            tx_cnt_q <= 2'd2;
        end
        else if (tx_valid_out && tx_ready_in)
        begin
            tx_cnt_q <= tx_cnt_q - 2'd1;
        end
    end

    assign tx_valid_out = (tx_cnt_q != 2'd0);
    assign tx_out = '{data: (tx_cnt_q == 2'd2) ? acc_q[15:8] : acc_q[7:0],
                      last: (tx_cnt_q == 2'd1)};
endmodule
`default_nettype wire

// ### rtl/bhr_pkg.sv
`default_nettype none
package bhr_pkg;
    typedef enum logic [7:0] {
        BHR_WAIT_MARK = 8'b0000_0001,
        BHR_LEN       = 8'b0000_0010,
        BHR_ADDR_HI   = 8'b0000_0100,
        BHR_ADDR_LO   = 8'b0000_1000,
        BHR_TYPE      = 8'b0001_0000,
        BHR_PAYLOAD   = 8'b0010_0000,
        BHR_CSUM      = 8'b0100_0000,
        BHR_IDLE      = 8'b1000_0000
    } bhr_state_e;

    typedef struct packed {
        logic [7:0]  data;
        logic [15:0] addr;
        logic [15:0] seg;
    } bhr_rec_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } bhr_tx_s;
endpackage
`default_nettype wire
